// ==== design/fsli_lamp_pattern.sv ====
// Purpose: Turns a lamp pattern code into an on/off lamp drive.
// Assumes: ms_tick is a one-cycle pulse once per millisecond.
// Notes:   A change of pattern restarts the sequence at its first on phase.
`default_nettype none

module fsli_lamp_pattern (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ms_tick,
   input wire fsli_pkg::fsli_pat_t pat,
   output var logic lamp
);
   import fsli_pkg::*;

   typedef struct packed {
      fsli_pat_t pat_q;
      logic [1:0] phase_q;
      logic [MSCNT_W-1:0] cnt_q;
      logic lamp_q;
   } fsli_lp_t;

   fsli_lp_t s_q;
   fsli_lp_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // Phase tables

   function automatic logic [MSCNT_W-1:0] phase_len(input fsli_pat_t p,
                                                    input logic [1:0] ph);
      logic [MSCNT_W-1:0] len;
      len = MSCNT_W'(BLINK_MS);
      if (p == PAT_SINGLE && ph == 2'h1) begin
         len = MSCNT_W'(LONG_OFF_MS);
      end else if (p == PAT_DOUBLE && ph == 2'h3) begin
         len = MSCNT_W'(LONG_OFF_MS);
      end
      return len;
   endfunction

   function automatic logic [1:0] last_phase(input fsli_pat_t p);
      logic [1:0] lp;
      lp = 2'h0;
      if (p == PAT_BLINK || p == PAT_SINGLE) begin
         lp = 2'h1;
      end else if (p == PAT_DOUBLE) begin
         lp = 2'h3;
      end
      return lp;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      s_d = s_q;
      if (pat != s_q.pat_q) begin
         s_d.pat_q = pat;
         s_d.phase_q = 2'h0;
         s_d.cnt_q = '0;
      end else if (ms_tick) begin
         if (MSCNT_W'(s_q.cnt_q + 1'b1) >= phase_len(s_q.pat_q, s_q.phase_q))
         begin
            s_d.cnt_q = '0;
            if (s_q.phase_q == last_phase(s_q.pat_q)) begin
               s_d.phase_q = 2'h0;
            end else begin
               s_d.phase_q = 2'(s_q.phase_q + 1'b1);
            end
         end else begin
            s_d.cnt_q = MSCNT_W'(s_q.cnt_q + 1'b1);
         end
      end
      // Even phases are lit, odd ones dark
      case (s_d.pat_q)
         PAT_OFF: s_d.lamp_q = 1'b0;
         PAT_ON: s_d.lamp_q = 1'b1;
         default: s_d.lamp_q = ~s_d.phase_q[0];
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q <= '{pat_q: RESET_PAT, phase_q: 2'h0, cnt_q: '0, lamp_q: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign lamp = s_q.lamp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   phase_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
      s_q.cnt_q < phase_len(s_q.pat_q, s_q.phase_q))
      else $error("lamp phase counter past its phase length");

endmodule

`default_nettype wire

// ==== design/fsli_link_lamp.sv ====
// Purpose: Drives one port link/activity lamp.
// Assumes: link_act pulses once per frame seen on the port.
// Notes:   Activity is stretched so short bursts still flicker visibly.
`default_nettype none

module fsli_link_lamp (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ms_tick,
   input wire logic link_up,
   input wire logic link_act,
   output var logic lamp
);
   import fsli_pkg::*;

   typedef struct packed {
      logic [MSCNT_W-1:0] hold_q;
      logic [MSCNT_W-1:0] fcnt_q;
      logic flick_q;
      logic lamp_q;
   } fsli_ll_t;

   fsli_ll_t s_q;
   fsli_ll_t s_d;

   always_comb begin
      s_d = s_q;
      if (link_act) begin
         s_d.hold_q = MSCNT_W'(ACT_HOLD_MS);
      end else if (ms_tick && s_q.hold_q != '0) begin
         s_d.hold_q = MSCNT_W'(s_q.hold_q - 1'b1);
      end
      if (ms_tick) begin
         if (MSCNT_W'(s_q.fcnt_q + 1'b1) >= MSCNT_W'(FLICKER_MS)) begin
            s_d.fcnt_q = '0;
            s_d.flick_q = ~s_q.flick_q;
         end else begin
            s_d.fcnt_q = MSCNT_W'(s_q.fcnt_q + 1'b1);
         end
      end
      if (!link_up) begin
         s_d.lamp_q = 1'b0;
      end else if (s_d.hold_q != '0) begin
         s_d.lamp_q = s_d.flick_q;
      end else begin
         s_d.lamp_q = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q <= '{hold_q: '0, fcnt_q: '0, flick_q: 1'b0, lamp_q: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign lamp = s_q.lamp_q;

   no_link_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !link_up |=> !lamp)
      else $error("link lamp lit with no link");

   idle_steady_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (link_up && s_q.hold_q == '0 && !link_act) |=> lamp)
      else $error("link lamp not steady on idle link");

endmodule

`default_nettype wire

// ==== design/fsli_pkg.sv ====
// Purpose: Shared constants and types for the fieldbus state and lamp logic.
// Assumes: A 20 MHz system clock; lamp timing runs from a millisecond tick.
// Notes:   Lamp times are in milliseconds, and the tick period is in cycles.
`default_nettype none

package fsli_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock rate and millisecond tick
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int TICKS_PER_MS = CLK_HZ / MS_PER_S;
   localparam int TICK_W = 15;

   ////////////////////////////////////////////////////////////////////////////
   // Lamp timing in milliseconds
   localparam int BLINK_MS = 200;
   localparam int LONG_OFF_MS = 1000;
   localparam int FLICKER_MS = 50;
   localparam int ACT_HOLD_MS = 100;
   localparam int MSCNT_W = 10;

   ////////////////////////////////////////////////////////////////////////////
   // Communication states and lamp patterns
   typedef enum logic [2:0] {
      ST_INIT = 3'b001,
      ST_PREOP = 3'b010,
      ST_BOOT = 3'b011,
      ST_SAFEOP = 3'b100,
      ST_OP = 3'b101
   } fsli_state_t;

   typedef enum logic [2:0] {
      PAT_OFF = 3'b000,
      PAT_ON = 3'b001,
      PAT_BLINK = 3'b010,
      PAT_SINGLE = 3'b011,
      PAT_DOUBLE = 3'b100
   } fsli_pat_t;

   localparam fsli_state_t RESET_STATE = ST_INIT;
   localparam fsli_pat_t RESET_PAT = PAT_OFF;

endpackage

`default_nettype wire

// ==== design/fsli_top.sv ====
// Purpose: Communication state machine and status lamps of the fieldbus port.
// Assumes: Master requests arrive as one-cycle pulses with a target state.
// Notes:   All lamp timing runs off one shared millisecond tick.
`default_nettype none

module fsli_top #(
   parameter int MS_CYCLES = fsli_pkg::TICKS_PER_MS
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_state,
   input wire logic setting_reject,
   input wire logic in_link_up,
   input wire logic in_link_act,
   input wire logic out_link_up,
   input wire logic out_link_act,
   input wire logic clock_sync_lock_err,
   input wire logic sm_wdog_err,
   input wire logic servo_alarm,
   output fsli_pkg::fsli_state_t comm_state,
   output logic cmd_done,
   output logic cmd_refused,
   output logic comm_reinit,
   output logic mbx_en,
   output logic foe_en,
   output logic pdo_tx_en,
   output logic pdo_rx_en,
   output logic in_port_link_lamp,
   output logic out_port_link_lamp,
   output logic run_lamp,
   output logic err_lamp
);
   import fsli_pkg::*;

   typedef struct packed {
      logic [TICK_W-1:0] tick_cnt_q;
      logic ms_tick_q;
      fsli_state_t st_q;
      logic done_q;
      logic refused_q;
      logic reinit_q;
      logic mbx_q;
      logic foe_q;
      logic pdo_tx_q;
      logic pdo_rx_q;
      logic bad_cmd_q;
      fsli_pat_t run_pat_q;
      fsli_pat_t err_pat_q;
   } fsli_top_t;

   fsli_top_t s_q;
   fsli_top_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic logic req_allowed(input fsli_state_t cur,
                                        input logic [2:0] req);
      logic ok;
      ok = 1'b0;
      case (req)
         ST_INIT: ok = 1'b1;
         ST_BOOT: ok = (cur == ST_INIT) || (cur == ST_BOOT);
         ST_PREOP: ok = (cur != ST_BOOT);
         ST_SAFEOP: ok = (cur == ST_PREOP) || (cur == ST_SAFEOP) ||
                         (cur == ST_OP);
         ST_OP: ok = (cur == ST_SAFEOP) || (cur == ST_OP);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Traffic gates per state: {mailbox, file access, pdo tx, pdo rx}
   function automatic logic [3:0] traffic(input fsli_state_t st);
      logic [3:0] t;
      case (st)
         ST_BOOT: t = 4'h4;
         ST_INIT: t = 4'h0;
         ST_PREOP: t = 4'hc;
         ST_SAFEOP: t = 4'he;
         ST_OP: t = 4'hf;
         default: t = 4'h0;
      endcase
      return t;
   endfunction

   function automatic fsli_pat_t run_pattern(input fsli_state_t st);
      fsli_pat_t p;
      case (st)
         ST_PREOP: p = PAT_BLINK;
         ST_SAFEOP: p = PAT_SINGLE;
         ST_OP: p = PAT_ON;
         default: p = PAT_OFF;
      endcase
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d = s_q;
      s_d.done_q = 1'b0;
      s_d.refused_q = 1'b0;
      s_d.reinit_q = 1'b0;

      // Free-running millisecond tick shared by all lamps
      if (s_q.tick_cnt_q >= TICK_W'(MS_CYCLES - 1)) begin
         s_d.tick_cnt_q = '0;
         s_d.ms_tick_q = 1'b1;
      end else begin
         s_d.tick_cnt_q = TICK_W'(s_q.tick_cnt_q + 1'b1);
         s_d.ms_tick_q = 1'b0;
      end

      if (cmd_valid) begin
         if (req_allowed(s_q.st_q, cmd_state)) begin
            s_d.st_q = fsli_state_t'(cmd_state);
            s_d.done_q = 1'b1;
            s_d.reinit_q = (cmd_state == ST_INIT) && (s_q.st_q != ST_INIT);
         end else begin
            s_d.refused_q = 1'b1;
         end
      end

      // sticky invalid request flag
      // Cleared by a good request, but a setting rejection in the same cycle wins
      if (s_d.done_q) begin
         s_d.bad_cmd_q = 1'b0;
      end
      if (s_d.refused_q || setting_reject) begin
         s_d.bad_cmd_q = 1'b1;
      end

      {s_d.mbx_q, s_d.foe_q, s_d.pdo_tx_q, s_d.pdo_rx_q} = traffic(s_d.st_q);

      s_d.run_pat_q = run_pattern(s_d.st_q);

      if (servo_alarm) begin
         s_d.err_pat_q = PAT_ON;
      end else if (sm_wdog_err) begin
         s_d.err_pat_q = PAT_DOUBLE;
      end else if (clock_sync_lock_err) begin
         s_d.err_pat_q = PAT_SINGLE;
      end else if (s_d.bad_cmd_q) begin
         s_d.err_pat_q = PAT_BLINK;
      end else begin
         s_d.err_pat_q = PAT_OFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   // Reset lands in init with all traffic closed
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q <= '{tick_cnt_q: '0, ms_tick_q: 1'b0, st_q: RESET_STATE,
                  done_q: 1'b0, refused_q: 1'b0, reinit_q: 1'b0,
                  mbx_q: 1'b0, foe_q: 1'b0, pdo_tx_q: 1'b0, pdo_rx_q: 1'b0,
                  bad_cmd_q: 1'b0, run_pat_q: RESET_PAT,
                  err_pat_q: RESET_PAT};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign comm_state = s_q.st_q;
   assign cmd_done = s_q.done_q;
   assign cmd_refused = s_q.refused_q;
   assign comm_reinit = s_q.reinit_q;
   assign mbx_en = s_q.mbx_q;
   assign foe_en = s_q.foe_q;
   assign pdo_tx_en = s_q.pdo_tx_q;
   assign pdo_rx_en = s_q.pdo_rx_q;

   ////////////////////////////////////////////////////////////////////////////
   // Lamp drivers

   fsli_link_lamp u_in_lamp (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ms_tick(s_q.ms_tick_q),
      .link_up(in_link_up),
      .link_act(in_link_act),
      .lamp(in_port_link_lamp)
   );

   fsli_link_lamp u_out_lamp (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ms_tick(s_q.ms_tick_q),
      .link_up(out_link_up),
      .link_act(out_link_act),
      .lamp(out_port_link_lamp)
   );

   fsli_lamp_pattern u_run_lamp (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ms_tick(s_q.ms_tick_q),
      .pat(s_q.run_pat_q),
      .lamp(run_lamp)
   );

   fsli_lamp_pattern u_err_lamp (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ms_tick(s_q.ms_tick_q),
      .pat(s_q.err_pat_q),
      .lamp(err_lamp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   master_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !$stable(comm_state) |-> $past(cmd_valid))
      else $error("state changed without a master request");

   boot_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (cmd_valid && cmd_state == ST_BOOT && comm_state != ST_INIT &&
       comm_state != ST_BOOT)
      |=> cmd_refused && comm_state == $past(comm_state))
      else $error("boot entered from a state other than init");

   boot_traffic_a: assert property (@(posedge mclk) disable iff (sys_rst)
      comm_state == ST_BOOT
      |-> foe_en && !mbx_en && !pdo_tx_en && !pdo_rx_en)
      else $error("wrong traffic gates in boot");

   init_block_a: assert property (@(posedge mclk) disable iff (sys_rst)
      comm_state == ST_INIT
      |-> !foe_en && !mbx_en && !pdo_tx_en && !pdo_rx_en)
      else $error("traffic open in init");

   reinit_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (cmd_valid && cmd_state == ST_INIT && comm_state != ST_INIT)
      |=> comm_reinit ##1 !comm_reinit)
      else $error("reinit pulse missing or too long");

   preop_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      comm_state == ST_PREOP |-> mbx_en && !pdo_tx_en && !pdo_rx_en)
      else $error("wrong traffic gates in pre-operational");

   safeop_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      comm_state == ST_SAFEOP |-> mbx_en && pdo_tx_en && !pdo_rx_en)
      else $error("wrong traffic gates in safe-operational");

   op_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      comm_state == ST_OP |-> mbx_en && pdo_tx_en && pdo_rx_en)
      else $error("wrong traffic gates in operational");

   run_pattern_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (comm_state == ST_OP |-> s_q.run_pat_q == PAT_ON) and
      (comm_state == ST_INIT |-> s_q.run_pat_q == PAT_OFF))
      else $error("run lamp pattern does not match state");

   refuse_blink_a: assert property (@(posedge mclk) disable iff (sys_rst)
      cmd_refused |-> s_q.err_pat_q == PAT_BLINK ||
      $past(servo_alarm || sm_wdog_err || clock_sync_lock_err))
      else $error("refused request not shown on error lamp");

   alarm_lamp_a: assert property (@(posedge mclk) disable iff (sys_rst)
      servo_alarm ##1 servo_alarm |=> err_lamp)
      else $error("error lamp dark during servo alarm");

   err_order_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (sm_wdog_err && !servo_alarm) |=> s_q.err_pat_q == PAT_DOUBLE)
      else $error("watchdog error not given priority");

   err_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (s_q.err_pat_q == PAT_OFF) ##1 (s_q.err_pat_q == PAT_OFF)
      |-> !err_lamp)
      else $error("error lamp lit with no error pending");

   reach_op_c: cover property (@(posedge mclk) disable iff (sys_rst)
      comm_state == ST_SAFEOP ##1 comm_state == ST_OP);

   reach_boot_c: cover property (@(posedge mclk) disable iff (sys_rst)
      comm_state == ST_INIT ##1 comm_state == ST_BOOT);

   refused_c: cover property (@(posedge mclk) disable iff (sys_rst)
      cmd_refused);

   wdog_flash_c: cover property (@(posedge mclk) disable iff (sys_rst)
      s_q.err_pat_q == PAT_DOUBLE && err_lamp);

endmodule

`default_nettype wire

// ==== verification/fsli_master_model.sv ====
// Purpose: Model of the fieldbus master that issues state requests.
// Assumes: Requests launch at the falling edge of mclk.
// Notes:   Idle request code is inverted so stale values are not trusted.
`default_nettype none

module fsli_master_model (
   output logic cmd_valid,
   output logic [2:0] cmd_state,
   input wire logic mclk
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      cmd_valid = 1'b0;
      cmd_state = 3'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one acyclic request
   task automatic send(input logic [2:0] code);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_state = code;
      @(negedge mclk);
      cmd_valid = 1'b0;
      cmd_state = ~code;
   endtask
endmodule

`default_nettype wire

// ==== verification/tb_fsli_top.sv ====
// Purpose: Self-checking bench for the fieldbus state and lamp logic.
// Assumes: MS_CYCLES of 4, so one lamp millisecond is four clocks.
// Notes:   Lamp on and off times allow one millisecond of tick phase error, the flicker off time two.
`default_nettype none

module tb_fsli_top;
   timeunit 1ns;
   timeprecision 1ns;
   import fsli_pkg::*;
   localparam int MS = 4;
   localparam int TOL = 4;
   logic mclk, sys_rst, cmd_valid, setting_reject;
   logic [2:0] cmd_state;
   logic [1:0] link_up, link_act;
   logic sync_err, wdog_err, alarm;
   fsli_state_t comm_state, cur;
   logic cmd_done, cmd_refused, comm_reinit;
   logic mbx_en, foe_en, pdo_tx_en, pdo_rx_en;
   wire [3:0] lamp;
   logic [9:0] note_q[$];
   logic [9:0] got;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;

   fsli_master_model i_master (.cmd_valid(cmd_valid),
      .cmd_state(cmd_state), .mclk(mclk));

   fsli_top #(.MS_CYCLES(MS)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
      .cmd_valid(cmd_valid), .cmd_state(cmd_state),
      .setting_reject(setting_reject), .in_link_up(link_up[0]),
      .in_link_act(link_act[0]), .out_link_up(link_up[1]),
      .out_link_act(link_act[1]), .clock_sync_lock_err(sync_err),
      .sm_wdog_err(wdog_err), .servo_alarm(alarm),
      .comm_state(comm_state), .cmd_done(cmd_done),
      .cmd_refused(cmd_refused), .comm_reinit(comm_reinit),
      .mbx_en(mbx_en), .foe_en(foe_en), .pdo_tx_en(pdo_tx_en),
      .pdo_rx_en(pdo_rx_en), .in_port_link_lamp(lamp[0]),
      .out_port_link_lamp(lamp[1]), .run_lamp(lamp[2]),
      .err_lamp(lamp[3]));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare tasks, one for request results and one for counts
   task automatic chk(input string w, input logic [9:0] e,
                      input logic [9:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic chk_n(input string w, input int e, input int g,
                        input int t);
      cmp_count++;
      if (g < e - t || g > e + t) begin
         n_mismatch++;
         $display("BAD %s expected %0d seen %0d", w, e, g);
      end
   endtask

   task automatic end_of_test();
      if (note_q.size() != 0) begin
         n_mismatch++;
         $display("BAD pending results expected 0 seen %0d", note_q.size());
      end
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reference transition table
   function automatic logic ok(fsli_state_t c, logic [2:0] r);
      case (r)
         3'h1: ok = 1'b1;
         3'h2: ok = (c != ST_BOOT);
         3'h3: ok = (c == ST_INIT || c == ST_BOOT);
         3'h4: ok = (c == ST_PREOP || c == ST_SAFEOP || c == ST_OP);
         3'h5: ok = (c == ST_SAFEOP || c == ST_OP);
         default: ok = 1'b0;
      endcase
   endfunction

   // Note the expected answer, then let the master send it
   task automatic req(input logic [2:0] r);
      logic a;
      fsli_state_t n;
      a = ok(cur, r);
      n = a ? fsli_state_t'(r) : cur;
      note_q.push_back({a, !a, a && r == 3'h1 && cur != ST_INIT,
         n != ST_INIT && n != ST_BOOT, n != ST_INIT,
         n == ST_SAFEOP || n == ST_OP, n == ST_OP, n});
      cur = n;
      i_master.send(r);
   endtask

   // Result watcher: oldest note against each answer
   always @(negedge mclk) begin
      if (!sys_rst && (cmd_done === 1'b1 || cmd_refused === 1'b1)) begin
         if (note_q.size() == 0)
            chk("unasked result", 10'h000, 10'h3ff);
         else begin
            got = {cmd_done, cmd_refused, comm_reinit, mbx_en, foe_en,
               pdo_tx_en, pdo_rx_en, comm_state};
            chk("request", note_q.pop_front(), got);
         end
      end
   end

   // Hang guard, well above the expected run length
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 80000) begin
         n_mismatch++;
         $display("BAD timeout expected done seen running");
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lamp measurement helpers
   task automatic run_len(input int s, input logic v, output int n);
      n = 0;
      while (lamp[s] === v && n < 9000) begin
         @(negedge mclk);
         n++;
      end
   endtask

   // Skip any phase in progress unless the pattern was just started
   task automatic seg(input int s, input bit skip, input int hi,
                      input int lo);
      int n;
      if (skip)
         run_len(s, 1'b1, n);
      run_len(s, 1'b0, n);
      run_len(s, 1'b1, n);
      chk_n("lamp on time", hi * MS, n, TOL);
      run_len(s, 1'b0, n);
      chk_n("lamp off time", lo * MS, n, TOL);
   endtask

   task automatic stay(input int s, input logic v, input int k);
      int bad;
      bad = 0;
      repeat (3) @(negedge mclk);
      repeat (k) begin
         @(negedge mclk);
         if (lamp[s] !== v)
            bad++;
      end
      chk_n("lamp steady", 0, bad, 0);
   endtask

   task automatic link_test(input int p);
      int lo;
      stay(p, 1'b0, 50);
      link_up[p] = 1'b1;
      stay(p, 1'b1, 300);
      link_act[p] = 1'b1;
      @(negedge mclk);
      link_act[p] = 1'b0;
      lo = 0;
      repeat (600) begin
         @(negedge mclk);
         if (lamp[p] === 1'b0)
            lo++;
      end
      chk_n("flicker off time", 50 * MS, lo, 2 * TOL);
      stay(p, 1'b1, 100);
      link_up[p] = 1'b0;
      stay(p, 1'b0, 50);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      setting_reject = 1'b0;
      link_up = 2'h0;
      link_act = 2'h0;
      sync_err = 1'b0;
      wdog_err = 1'b0;
      alarm = 1'b0;
      cur = ST_INIT;
      void'($urandom(32'hbd1f4c08));
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      repeat (300) req(3'($urandom_range(7)));
      $display("request table test done");
      req(3'h1);
      stay(2, 1'b0, 400);
      req(3'h2);
      seg(2, 1, 200, 200);
      req(3'h4);
      seg(2, 1, 200, 1000);
      req(3'h5);
      stay(2, 1'b1, 400);
      stay(3, 1'b0, 400);
      $display("run lamp test done");
      setting_reject = 1'b1;
      @(negedge mclk);
      setting_reject = 1'b0;
      seg(3, 0, 200, 200);
      req(3'h1);
      stay(3, 1'b0, 100);
      sync_err = 1'b1;
      seg(3, 0, 200, 1000);
      sync_err = 1'b0;
      stay(3, 1'b0, 50);
      sync_err = 1'b1;
      wdog_err = 1'b1;
      seg(3, 0, 200, 200);
      seg(3, 0, 200, 1000);
      alarm = 1'b1;
      stay(3, 1'b1, 2000);
      {alarm, wdog_err, sync_err} = 3'h0;
      stay(3, 1'b0, 100);
      $display("error lamp test done");
      link_test(0);
      link_test(1);
      $display("link lamp test done");
      end_of_test();
   end
endmodule

`default_nettype wire
